// file: hw/pec_pkg.sv
// Package: constants and carrier types of the performance event counters.
// Assumes one core clock domain and a plain register port.
package pec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Counter counts and widths
  localparam int PEC_NUM_CORE = 6;
  localparam int PEC_NUM_L3   = 6;
  localparam int PEC_NUM_DF   = 4;
  localparam int PEC_CTR_W    = 48;
  localparam int PEC_DATA_W   = 64;
  localparam int PEC_ADDR_W   = 6;
  localparam int PEC_HI_W     = 16;
  localparam int PEC_INC_W    = 8;
  localparam int PEC_NARROW_W = 4;
  localparam logic [PEC_INC_W-1:0] PEC_NARROW_MAX = 8'h0f;
  localparam logic [9:0]           PEC_WIDE_MAX   = 10'h0ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: region in address bits 5:3, index in bits 2:0
  localparam logic [2:0] PEC_REGION_CTL = 3'h0;
  localparam logic [2:0] PEC_REGION_CTR = 3'h1;
  localparam logic [2:0] PEC_REGION_L3  = 3'h2;
  localparam logic [2:0] PEC_REGION_DF  = 3'h3;

  // Field layout of counter_control_reg
  localparam int PEC_CODE_LO_LSB = 0;
  localparam int PEC_MASK_LSB    = 8;
  localparam int PEC_EN_BIT      = 22;
  localparam int PEC_INV_BIT     = 23;
  localparam int PEC_CODE_HI_LSB = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Event codes
  localparam logic [11:0] PEC_EV_PIPE  = 12'h000;
  localparam logic [11:0] PEC_EV_IDLE  = 12'h001;
  localparam logic [11:0] PEC_EV_X87   = 12'h002;
  localparam logic [11:0] PEC_EV_VEC   = 12'h003;
  localparam logic [11:0] PEC_EV_MOVE  = 12'h004;
  localparam logic [11:0] PEC_EV_SER   = 12'h005;
  localparam logic [11:0] PEC_EV_MERGE = 12'hfff;

  // Sub-event mask bits of the vector event that count twice
  localparam int PEC_SP_FMA_BIT = 3;
  localparam int PEC_DP_FMA_BIT = 7;

  // Counter read instruction index map
  localparam logic [3:0] PEC_IDX_CORE_LAST = 4'h5;
  localparam logic [3:0] PEC_IDX_L3_BASE   = 4'ha;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic [11:0] code;
    logic [7:0]  sub_event_mask;
    logic        en;
    logic        inv;
  } pec_ctl_type;

  typedef struct packed {
    logic [3:0]      pipe_uop;
    logic [3:0]      pipe_multi_uop;
    logic            sched_idle;
    logic [2:0][3:0] x87_ops;
    logic [7:0][4:0] vec_ops;
    logic [3:0]      move_evt;
    logic [3:0]      serial_evt;
  } pec_evt_src_type;

  typedef struct packed {
    logic [PEC_ADDR_W-1:0] addr;
    logic [PEC_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } pec_bus_req_type;

  typedef struct packed {
    logic       valid;
    logic [3:0] idx;
  } pec_cri_req_type;

endpackage : pec_pkg

// file: hw/pec_event_decode.sv
// Module: turns one counter's control setting and the pipeline event
// sources into that counter's increment for this cycle.
// Assumes event sources come from logic on the same core clock.
`timescale 1ns/100ps
`default_nettype none
module pec_event_decode (
  // Control setting
  input  wire pec_pkg::pec_ctl_type     ctl_i,
  // Pipeline events
  input  wire pec_pkg::pec_evt_src_type src_i,
  // Increment, saturated to eight bits
  output logic [pec_pkg::PEC_INC_W-1:0] inc_o
);
  import pec_pkg::*;

  logic [9:0] sum;

  ////////////////////////////////////////////////////////////////////////////
  // summing selected sub-events
  always_comb begin
    sum = '0;
    unique case (ctl_i.code)
      PEC_EV_PIPE: begin
        for (int p = 0; p < 4; p++) begin
          sum = sum + 10'(src_i.pipe_uop[p] & ctl_i.sub_event_mask[p]);
          sum = sum + 10'(src_i.pipe_multi_uop[p] & ctl_i.sub_event_mask[p+4]);
        end
      end
      PEC_EV_IDLE: begin
        sum = 10'(src_i.sched_idle ^ ctl_i.inv);
      end
      PEC_EV_X87: begin
        for (int k = 0; k < 3; k++) begin
          if (ctl_i.sub_event_mask[k]) begin
            sum = sum + {6'h0, src_i.x87_ops[k]};
          end
        end
      end
      PEC_EV_VEC: begin
        for (int k = 0; k < 8; k++) begin
          if (ctl_i.sub_event_mask[k]) begin
            if (k == PEC_SP_FMA_BIT || k == PEC_DP_FMA_BIT) begin
              sum = sum + {4'h0, src_i.vec_ops[k], 1'b0};
            end else begin
              sum = sum + {5'h0, src_i.vec_ops[k]};
            end
          end
        end
      end
      PEC_EV_MOVE: begin
        for (int k = 0; k < 4; k++) begin
          sum = sum + 10'(src_i.move_evt[k] & ctl_i.sub_event_mask[k]);
        end
      end
      PEC_EV_SER: begin
        for (int k = 0; k < 4; k++) begin
          sum = sum + 10'(src_i.serial_evt[k] & ctl_i.sub_event_mask[k]);
        end
      end
      default: begin
        sum = '0;
      end
    endcase
    inc_o = (sum > PEC_WIDE_MAX) ? PEC_WIDE_MAX[PEC_INC_W-1:0] : sum[PEC_INC_W-1:0];
  end

endmodule : pec_event_decode
`default_nettype wire

// file: hw/pec_perf_counters.sv
// Module: per-thread core event counters with pair merging, L3 and
// interconnect counters, register port and counter read instruction port.
// Assumes all inputs come from logic on clk_i; no synchronisers needed.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Six core, six L3, four interconnect counters
// - Read index 0-5 core, A-F L3
// - Unmerged counter adds at most 15
// - Wide event plus idle merge makes 64 bits
// - Even read of merged pair gives 64 bits
// - Merge code on even counter: undetermined
// - Narrow event with merge odd: undetermined
// - Event code split in bits 11:8, 7:0
// - Event 000h counts pipe dispatches
// - Event 001h counts idle, inverted busy
// - Event 002h counts legacy float retires
// - Event 003h counts vector float operations
// - Multiply-add counts two operations
// - Event 004h counts move elimination events
// - Event 005h counts serializing retires
module pec_perf_counters #(
  parameter int N_CORE = pec_pkg::PEC_NUM_CORE,
  parameter int N_L3   = pec_pkg::PEC_NUM_L3,
  parameter int N_DF   = pec_pkg::PEC_NUM_DF
) (
  // Clock and reset
  input  wire  logic                              clk_i,
  input  wire  logic                              rst_i,
  // Register port
  input  wire  pec_pkg::pec_bus_req_type          bus_i,
  output logic [pec_pkg::PEC_DATA_W-1:0]          bus_rdata_o,
  // Counter read instruction port
  input  wire  pec_pkg::pec_cri_req_type          cri_i,
  output logic [pec_pkg::PEC_DATA_W-1:0]          cri_data_o,
  output logic                                    cri_fault_o,
  // Event sources
  input  wire  pec_pkg::pec_evt_src_type          evt_i,
  input  wire  logic [N_L3-1:0][3:0]              l3_inc_i,
  input  wire  logic [N_DF-1:0][3:0]              df_inc_i
);
  import pec_pkg::*;

  typedef struct packed {
    pec_ctl_type [N_CORE-1:0]               ctl;
    logic        [N_CORE-1:0][PEC_CTR_W-1:0] ctr;
    logic        [N_L3-1:0][PEC_CTR_W-1:0]   l3;
    logic        [N_DF-1:0][PEC_CTR_W-1:0]   df;
    logic        [PEC_DATA_W-1:0]            rdata;
    logic        [PEC_DATA_W-1:0]            cri_data;
    logic                                    cri_fault;
  } pec_state_type;

  pec_state_type                    st_reg;
  pec_state_type                    st_next;
  logic [N_CORE-1:0][PEC_INC_W-1:0] inc;
  logic [N_CORE-1:0]                pair_on;
  logic [2:0]                       region;
  int                               sel;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic pec_ctl_type ctl_from_word(input logic [PEC_DATA_W-1:0] w);
    pec_ctl_type c;
    c.code           = {w[PEC_CODE_HI_LSB+:4], w[PEC_CODE_LO_LSB+:8]};
    c.sub_event_mask = w[PEC_MASK_LSB+:8];
    c.en             = w[PEC_EN_BIT];
    c.inv            = w[PEC_INV_BIT];
    return c;
  endfunction : ctl_from_word

  function automatic logic [PEC_DATA_W-1:0] ctl_to_word(input pec_ctl_type c);
    logic [PEC_DATA_W-1:0] w;
    w                     = '0;
    w[PEC_CODE_HI_LSB+:4] = c.code[11:8];
    w[PEC_CODE_LO_LSB+:8] = c.code[7:0];
    w[PEC_MASK_LSB+:8]    = c.sub_event_mask;
    w[PEC_EN_BIT]         = c.en;
    w[PEC_INV_BIT]        = c.inv;
    return w;
  endfunction : ctl_to_word

  // wide event with idle merge partner
  function automatic logic pair_merged(input pec_ctl_type ev, input pec_ctl_type od);
    return (ev.code == PEC_EV_VEC) && (od.code == PEC_EV_MERGE) && !od.en;
  endfunction : pair_merged

  function automatic logic [PEC_DATA_W-1:0] core_view(input pec_state_type s,
                                                      input logic [N_CORE-1:0] on,
                                                      input int i);
    if (on[i] && (i % 2 == 0)) begin
      return {s.ctr[i+1][PEC_HI_W-1:0], s.ctr[i]};
    end
    return PEC_DATA_W'(s.ctr[i]);
  endfunction : core_view

  function automatic logic [PEC_INC_W-1:0] narrow(input logic [PEC_INC_W-1:0] v);
    return (v > PEC_NARROW_MAX) ? PEC_NARROW_MAX : v;
  endfunction : narrow

  ////////////////////////////////////////////////////////////////////////////
  // Event decoders, one per core counter
  for (genvar g = 0; g < N_CORE; g++) begin : g_dec
    pec_event_decode u_dec (
      .ctl_i (st_reg.ctl[g]),
      .src_i (evt_i),
      .inc_o (inc[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pair detection
  // merge ends when code removed
  // merge code on even never merges
  always_comb begin
    pair_on = '0;
    for (int p = 0; p < N_CORE / 2; p++) begin
      pair_on[2*p]   = pair_merged(st_reg.ctl[2*p], st_reg.ctl[2*p+1]);
      pair_on[2*p+1] = pair_on[2*p];
    end
  end

  assign region = bus_i.addr[PEC_ADDR_W-1:3];
  assign sel    = int'(bus_i.addr[2:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [PEC_DATA_W-1:0] wide;
    int                    li;
    wide    = '0;
    li      = 0;
    st_next = st_reg;

    for (int p = 0; p < N_CORE / 2; p++) begin
      for (int h = 0; h < 2; h++) begin
        if (pair_on[2*p]) begin
          if (h == 0) begin
            wide = {st_reg.ctr[2*p+1][PEC_HI_W-1:0], st_reg.ctr[2*p]} + PEC_DATA_W'(inc[2*p]);
            st_next.ctr[2*p]                 = wide[PEC_CTR_W-1:0];
            st_next.ctr[2*p+1][PEC_HI_W-1:0] = wide[PEC_DATA_W-1:PEC_CTR_W];
          end
        end else if (st_reg.ctl[2*p+h].en) begin
          st_next.ctr[2*p+h] = st_reg.ctr[2*p+h] + PEC_CTR_W'(narrow(inc[2*p+h]));
        end
      end
    end

    for (int k = 0; k < N_L3; k++) begin
      st_next.l3[k] = st_reg.l3[k] + PEC_CTR_W'(l3_inc_i[k]);
    end
    for (int k = 0; k < N_DF; k++) begin
      st_next.df[k] = st_reg.df[k] + PEC_CTR_W'(df_inc_i[k]);
    end

    if (bus_i.wr) begin
      unique case (region)
        PEC_REGION_CTL: begin
          if (sel < N_CORE) begin
            st_next.ctl[sel] = ctl_from_word(bus_i.wdata);
          end
        end
        PEC_REGION_CTR: begin
          if (sel < N_CORE) begin
            st_next.ctr[sel] = bus_i.wdata[PEC_CTR_W-1:0];
          end
        end
        PEC_REGION_L3: begin
          if (sel < N_L3) begin
            st_next.l3[sel] = bus_i.wdata[PEC_CTR_W-1:0];
          end
        end
        PEC_REGION_DF: begin
          if (sel < N_DF) begin
            st_next.df[sel] = bus_i.wdata[PEC_CTR_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Register read, data valid one cycle after
    st_next.rdata = '0;
    if (bus_i.rd) begin
      unique case (region)
        PEC_REGION_CTL: begin
          if (sel < N_CORE) begin
            st_next.rdata = ctl_to_word(st_reg.ctl[sel]);
          end
        end
        PEC_REGION_CTR: begin
          if (sel < N_CORE) begin
            st_next.rdata = core_view(st_reg, pair_on, sel);
          end
        end
        PEC_REGION_L3: begin
          if (sel < N_L3) begin
            st_next.rdata = PEC_DATA_W'(st_reg.l3[sel]);
          end
        end
        PEC_REGION_DF: begin
          if (sel < N_DF) begin
            st_next.rdata = PEC_DATA_W'(st_reg.df[sel]);
          end
        end
        default: begin
        end
      endcase
    end

    st_next.cri_data  = '0;
    st_next.cri_fault = 1'b0;
    if (cri_i.valid) begin
      if (cri_i.idx <= PEC_IDX_CORE_LAST) begin
        st_next.cri_data = core_view(st_reg, pair_on, int'(cri_i.idx));
      end else if (cri_i.idx >= PEC_IDX_L3_BASE) begin
        li               = int'(cri_i.idx - PEC_IDX_L3_BASE);
        st_next.cri_data = PEC_DATA_W'(st_reg.l3[li]);
      end else begin
        st_next.cri_fault = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata_o = st_reg.rdata;
  assign cri_data_o  = st_reg.cri_data;
  assign cri_fault_o = st_reg.cri_fault;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [PEC_DATA_W-1:0] view0;
  assign view0 = {st_reg.ctr[1][PEC_HI_W-1:0], st_reg.ctr[0]};

  chk_narrow_step_cap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!pair_on[0] && st_reg.ctl[0].en && !bus_i.wr)
      |=> ((st_reg.ctr[0] - $past(st_reg.ctr[0])) <= PEC_CTR_W'(PEC_NARROW_MAX)))
    else $error("unmerged counter stepped above fifteen");

  chk_merged_wide_step: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pair_on[0] && !bus_i.wr)
      |=> (view0 == $past(view0) + PEC_DATA_W'($past(inc[0]))))
    else $error("merged pair did not take full increment");

  chk_even_full_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus_i.rd && bus_i.addr == {PEC_REGION_CTR, 3'h0} && pair_on[0])
      |=> (bus_rdata_o == $past(view0)))
    else $error("even read of merged pair not 64 bits");

  chk_core_index_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cri_i.valid && cri_i.idx == 4'h1)
      |=> (cri_data_o == PEC_DATA_W'($past(st_reg.ctr[1])) && !cri_fault_o))
    else $error("core counter index returned wrong value");

  chk_l3_index_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cri_i.valid && cri_i.idx == PEC_IDX_L3_BASE)
      |=> (cri_data_o == PEC_DATA_W'($past(st_reg.l3[0]))))
    else $error("L3 counter index returned wrong value");

  chk_gap_index_fault: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cri_i.valid && cri_i.idx > PEC_IDX_CORE_LAST && cri_i.idx < PEC_IDX_L3_BASE)
      |=> (cri_fault_o && cri_data_o == '0) ##1 !cri_fault_o || $past(cri_i.valid))
    else $error("unmapped read index did not fault");

  chk_ctl_code_split: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == {PEC_REGION_CTL, 3'h0})
      |=> (st_reg.ctl[0].code == {$past(bus_i.wdata[PEC_CODE_HI_LSB+:4]),
                                  $past(bus_i.wdata[PEC_CODE_LO_LSB+:8])}))
    else $error("event code fields not joined");

  chk_idle_invert: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_reg.ctl[1].code == PEC_EV_IDLE && st_reg.ctl[1].en && !pair_on[1] && !bus_i.wr)
      |=> (st_reg.ctr[1] - $past(st_reg.ctr[1])
           == PEC_CTR_W'($past(evt_i.sched_idle) ^ $past(st_reg.ctl[1].inv))))
    else $error("idle event count wrong");

  chk_l3_count_step: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !bus_i.wr |=> (st_reg.l3[2] - $past(st_reg.l3[2]) == PEC_CTR_W'($past(l3_inc_i[2]))))
    else $error("L3 counter did not follow its increment");

  chk_odd_upper_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pair_on[0] && !bus_i.wr)
      |=> (st_reg.ctr[1][PEC_CTR_W-1:PEC_HI_W] == $past(st_reg.ctr[1][PEC_CTR_W-1:PEC_HI_W])))
    else $error("merged odd counter upper bits moved");

  chk_odd_preload_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == {PEC_REGION_CTR, 3'h1})
      |=> (st_reg.ctr[1] == $past(bus_i.wdata[PEC_CTR_W-1:0])))
    else $error("odd counter preload not taken");

  chk_even_index_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cri_i.valid && cri_i.idx == 4'h0 && pair_on[0])
      |=> (cri_data_o == $past(view0) && !cri_fault_o))
    else $error("read index of merged even not 64 bits");

  chk_cri_idle_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !cri_i.valid |=> (cri_data_o == '0 && !cri_fault_o))
    else $error("read instruction result stood too long");

  chk_core_gap_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus_i.rd && region == PEC_REGION_CTR && sel >= N_CORE)
      |=> (bus_rdata_o == '0))
    else $error("read past last core counter not zero");

endmodule : pec_perf_counters
`default_nettype wire

// file: dv/pec_evt_model.sv
// Model: floating-point pipelines presenting one event pattern per request.
// Assumes requests come from the bench on the core clock.
`timescale 1ns/100ps
`default_nettype none
module pec_evt_model (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Pattern request
  input  wire logic                     load_i,
  input  wire pec_pkg::pec_evt_src_type pat_i,
  input  wire pec_pkg::pec_evt_src_type rest_i,
  // Event lines to the counters
  output var  pec_pkg::pec_evt_src_type evt_o
);
  import pec_pkg::*;
  ////////////////////////////////////////////////////////////
  // Events are per-cycle levels, so a pattern stands one cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_o <= '0;
    end else begin
      evt_o <= load_i ? pat_i : rest_i;
    end
  end
endmodule : pec_evt_model
`default_nettype wire

// file: dv/pec_perf_counters_bench.sv
// Testbench: self-checking run of the performance event counters.
// Assumes the pipeline model pec_evt_model and a 250 MHz core clock.
`timescale 1ns/100ps
`default_nettype none
module pec_perf_counters_bench;
  import pec_pkg::*;
  logic                  clk_i    = 1'b0;
  logic                  rst_i    = 1'b1;
  pec_bus_req_type       bus_i    = '0;
  pec_cri_req_type       cri_i    = '0;
  logic [PEC_DATA_W-1:0] bus_rdata_o;
  logic [PEC_DATA_W-1:0] cri_data_o;
  logic                  cri_fault_o;
  pec_evt_src_type       evt_i;
  pec_evt_src_type       pat      = '0;
  pec_evt_src_type       rest     = '0;
  logic                  load     = 1'b0;
  logic [5:0][3:0]       l3_inc_i = '0;
  logic [3:0][3:0]       df_inc_i = '0;
  int                    failures = 0;
  int                    n_checks = 0;
  int                    cycles   = 0;

  always #2 clk_i = ~clk_i;

  pec_perf_counters uut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .bus_rdata_o(bus_rdata_o),
    .cri_i(cri_i), .cri_data_o(cri_data_o), .cri_fault_o(cri_fault_o), .evt_i(evt_i),
    .l3_inc_i(l3_inc_i), .df_inc_i(df_inc_i));

  pec_evt_model model (.clk_i(clk_i), .rst_i(rst_i), .load_i(load), .pat_i(pat), .rest_i(rest),
    .evt_o(evt_i));

  ////////////////////////////////////////////////////////////
  // Helpers
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [63:0] ctl(input logic [11:0] code, input logic [7:0] mask,
                                      input logic en, input logic inv);
    return {28'h0, code[11:8], 8'h0, inv, en, 6'h0, mask, code[7:0]};
  endfunction : ctl

  task automatic wr(input logic [5:0] a, input logic [63:0] d);
    @(posedge clk_i);
    bus_i.addr  <= a;
    bus_i.wdata <= d;
    bus_i.wr    <= 1'b1;
    @(posedge clk_i);
    bus_i.wr    <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [63:0] exp);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.rd   <= 1'b1;
    @(posedge clk_i);
    bus_i.rd   <= 1'b0;
    #1;
    chk(bus_rdata_o, exp);
  endtask : rdc

  task automatic cric(input logic [3:0] i, input logic [63:0] exp, input logic flt);
    @(posedge clk_i);
    cri_i.idx   <= i;
    cri_i.valid <= 1'b1;
    @(posedge clk_i);
    cri_i.valid <= 1'b0;
    #1;
    chk(cri_data_o, exp);
    chk({63'h0, cri_fault_o}, {63'h0, flt});
  endtask : cric

  task automatic cfg(input logic [2:0] n, input logic [63:0] c);
    wr({3'h0, n}, c);
    wr({3'h1, n}, 64'h0);
  endtask : cfg

  task automatic pulse(input pec_evt_src_type p);
    @(posedge clk_i);
    pat  <= p;
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : pulse

  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rdc(6'h00, 64'h0);
    rdc(6'h08, 64'h0);
    wr(6'h0e, 64'h55);
    rdc(6'h0e, 64'h0);
    rdc(6'h06, 64'h0);
    cric(4'h6, 64'h0, 1'b1);
    cric(4'h9, 64'h0, 1'b1);
  endtask : t_reset

  task automatic t_outer();
    @(posedge clk_i);
    for (int k = 0; k < 6; k++) l3_inc_i[k] <= 4'(k + 1);
    for (int k = 0; k < 4; k++) df_inc_i[k] <= 4'(k + 9);
    @(posedge clk_i);
    @(posedge clk_i);
    l3_inc_i <= '0;
    df_inc_i <= '0;
    for (int k = 0; k < 6; k++) cric(4'ha + 4'(k), 64'(2 * (k + 1)), 1'b0);
    for (int k = 0; k < 4; k++) rdc(6'h18 + 6'(k), 64'(2 * (k + 9)));
  endtask : t_outer

  task automatic t_pipe();
    pec_evt_src_type p;
    p = '0;
    cfg(3'h0, ctl(PEC_EV_PIPE, 8'h3c, 1'b1, 1'b0));
    p.pipe_uop       = 4'hf;
    p.pipe_multi_uop = 4'h5;
    pulse(p);
    rdc(6'h08, 64'h3);
    wr(6'h00, 64'h0);
  endtask : t_pipe

  task automatic t_idle();
    pec_evt_src_type p;
    p = '0;
    cfg(3'h1, ctl(PEC_EV_IDLE, 8'h00, 1'b1, 1'b0));
    p.sched_idle = 1'b1;
    pulse(p);
    rdc(6'h09, 64'h1);
    @(posedge clk_i);
    rest.sched_idle <= 1'b1;
    cfg(3'h1, ctl(PEC_EV_IDLE, 8'h00, 1'b1, 1'b1));
    pulse('0);
    rdc(6'h09, 64'h1);
    wr(6'h01, 64'h0);
    rest.sched_idle <= 1'b0;
  endtask : t_idle

  task automatic t_x87();
    pec_evt_src_type p;
    p = '0;
    cfg(3'h2, ctl(PEC_EV_X87, 8'h05, 1'b1, 1'b0));
    p.x87_ops = {4'h3, 4'h2, 4'h1};
    pulse(p);
    wr(6'h02, ctl(PEC_EV_X87, 8'h07, 1'b1, 1'b0));
    p.x87_ops = {4'hf, 4'hf, 4'hf};
    pulse(p);
    rdc(6'h0a, 64'd19);
  endtask : t_x87

  task automatic t_misc();
    pec_evt_src_type p;
    p = '0;
    cfg(3'h3, ctl(PEC_EV_MOVE, 8'h0f, 1'b1, 1'b0));
    cfg(3'h4, ctl(PEC_EV_SER, 8'h0a, 1'b1, 1'b0));
    cfg(3'h5, ctl(12'h103, 8'hff, 1'b1, 1'b0));
    p.move_evt   = 4'hf;
    p.serial_evt = 4'hf;
    p.vec_ops[3] = 5'h04;
    pulse(p);
    rdc(6'h0b, 64'h4);
    rdc(6'h0c, 64'h2);
    rdc(6'h0d, 64'h0);
    rdc(6'h05, ctl(12'h103, 8'hff, 1'b1, 1'b0));
  endtask : t_misc

  task automatic t_merge();
    pec_evt_src_type p;
    p = '0;
    cfg(3'h0, ctl(PEC_EV_VEC, 8'hff, 1'b1, 1'b0));
    wr(6'h01, ctl(PEC_EV_MERGE, 8'h00, 1'b0, 1'b0));
    wr(6'h09, 64'h1);
    wr(6'h08, 64'hffff_ffff_fff0);
    for (int k = 0; k < 8; k++) p.vec_ops[k] = 5'(k + 1);
    pulse(p);
    rdc(6'h08, 64'h0002_0000_0000_0020);
    cric(4'h0, 64'h0002_0000_0000_0020, 1'b0);
    rdc(6'h09, 64'h2);
    wr(6'h01, 64'h0);
    pulse(p);
    rdc(6'h08, 64'h2f);
  endtask : t_merge

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin : main
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_outer();
    t_pipe();
    t_idle();
    t_x87();
    t_misc();
    t_merge();
    end_sim();
  end
endmodule : pec_perf_counters_bench
`default_nettype wire
